// ### logic/lpd_pwm_dimming.sv
// twelve channel pwm dimming generator with dither and exp curve
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module lpd_pwm_dimming
  import lpd_pkg::*;
#(
  parameter int NCH = 12
) (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [5:0] regAddr, // register address
  input wire logic [7:0] regWdata, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  input wire logic failSafe, // fail-safe state level
  input wire logic nvExpCurveEnable, // stored exp curve bit
  input wire logic [NCH*8-1:0] nvCoarseDuty, // stored coarse duties
  input wire logic [3:0] nvDimFreqSelect, // stored frequency field
  input wire logic nvInternalAddressSelect, // releases shared pins
  input wire logic addrOrBaseClockPin, // pin: external base clock
  input wire logic addrOrDimInLowGroup, // pin: low-active pwm, low half
  input wire logic addrOrDimInHighGroup, // pin: low-active pwm, high half
  output logic [NCH-1:0] currentOutputChannel // current source gates
);

  typedef struct packed {
    logic [NCH-1:0][7:0] coarse;
    logic [NCH-1:0][3:0] fine;
    logic [NCH-1:0][7:0] latC;
    logic [NCH-1:0][3:0] latF;
    logic [NCH-1:0][8:0] onT;
    logic [NCH-1:0] en;
    logic [NCH-1:0] out;
    logic expEn;
    logic shareEn;
    logic extSel;
    logic [3:0] freq;
    logic [11:0] divCnt;
    logic [7:0] baseCnt;
    logic [3:0] phase;
    logic [2:0] clkSync;
    logic [1:0] dimLoSync;
    logic [1:0] dimHiSync;
    logic failSafeDly;
    logic loadDone;
    logic [7:0] rdata;
  } lpd_state_t;

  lpd_state_t q;
  lpd_state_t d;
  logic extUse;
  logic extPwm;
  logic baseTick;
  logic periodEnd;
  logic [3:0] revPhase;

  // divider terminal count for each dimming frequency choice
  function automatic logic [11:0] divOf(input logic [3:0] f);
    divOf = 12'(LPD_CLK_HZ / (LPD_BASE_MUL * LPD_DIM_HZ[f]) - 1);
  endfunction

  // exponential curve: 32 codes per octave, top segment linear
  function automatic logic [11:0] expCode(input logic [7:0] v);
    logic [12:0] t;
    t = 13'({1'b1, v[4:0]}) << v[7:5];
    if (v[7:5] == 3'h7) begin
      expCode = LPD_EXP_TOP + {7'h00, v[4:0]};
    end else begin
      expCode = 12'(t - LPD_EXP_OFS);
    end
  endfunction

  // external clock needs both nv bit and select bit
  assign extUse = nvInternalAddressSelect & q.extSel;
  // shared pins become external pwm inputs
  assign extPwm = nvInternalAddressSelect;
  // internal divider tick, or synchronised external clock edge
  assign baseTick = extUse ? (q.clkSync[1] & ~q.clkSync[2])
                           : (q.divCnt >= divOf(q.freq));
  // period closes after 256 base ticks
  assign periodEnd = baseTick && (q.baseCnt == LPD_PERIOD_LAST);
  // bit reversed phase spreads dither pulses over the 16 periods
  assign revPhase = {q.phase[0], q.phase[1], q.phase[2], q.phase[3]};
  assign regRdata = q.rdata;
  assign currentOutputChannel = q.out;

  // next state
  always_comb begin
    logic [11:0] code;
    logic [7:0] src;
    logic dith;
    logic grp;
    d = q;
    code = '0;
    src = '0;
    dith = 1'b0;
    grp = 1'b0;
    // pin synchronisers; first stage feeds only the second
    d.clkSync = {q.clkSync[1:0], addrOrBaseClockPin};
    d.dimLoSync = {q.dimLoSync[0], addrOrDimInLowGroup};
    d.dimHiSync = {q.dimHiSync[0], addrOrDimInHighGroup};
    d.failSafeDly = failSafe;
    d.rdata = '0;
    // register writes
    if (regWr) begin
      for (int ch = 0; ch < NCH; ch++) begin
        // coarse write commits coarse and fine together
        if (regAddr == LPD_ADDR_COARSE0 + 6'(ch)) begin
          d.coarse[ch] = regWdata;
          d.latC[ch] = regWdata;
          d.latF[ch] = q.fine[ch];
        end
        // fine write alone is held back
        if (regAddr == LPD_ADDR_FINE0 + 6'(ch)) begin
          d.fine[ch] = regWdata[3:0];
        end
        if (ch < 8 && regAddr == LPD_ADDR_EN_LO) begin
          d.en[ch] = regWdata[ch % 8];
        end
        if (ch >= 8 && regAddr == LPD_ADDR_EN_HI) begin
          d.en[ch] = regWdata[ch % 8];
        end
      end
      if (regAddr == LPD_ADDR_CTRL) begin
        d.expEn = regWdata[LPD_CTRL_EXP];
        d.shareEn = regWdata[LPD_CTRL_SHARE];
        d.extSel = regWdata[LPD_CTRL_EXTCLK];
      end
      if (regAddr == LPD_ADDR_FREQ) begin
        d.freq = regWdata[3:0];
      end
    end
    // register reads; unmapped addresses read zero
    if (regRd) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (regAddr == LPD_ADDR_COARSE0 + 6'(ch)) begin
          d.rdata = q.coarse[ch];
        end
        if (regAddr == LPD_ADDR_FINE0 + 6'(ch)) begin
          d.rdata = {4'h0, q.fine[ch]};
        end
        if (ch < 8 && regAddr == LPD_ADDR_EN_LO) begin
          d.rdata[ch % 8] = q.en[ch];
        end
        if (ch >= 8 && regAddr == LPD_ADDR_EN_HI) begin
          d.rdata[ch % 8] = q.en[ch];
        end
      end
      if (regAddr == LPD_ADDR_CTRL) begin
        d.rdata[LPD_CTRL_EXP] = q.expEn;
        d.rdata[LPD_CTRL_SHARE] = q.shareEn;
        d.rdata[LPD_CTRL_EXTCLK] = q.extSel;
      end
      if (regAddr == LPD_ADDR_FREQ) begin
        d.rdata = {4'h0, q.freq};
      end
      if (regAddr == LPD_ADDR_STATUS) begin
        d.rdata[LPD_STAT_FAILSAFE] = failSafe;
        d.rdata[LPD_STAT_EXTCLK] = extUse;
      end
    end
    // reload after reset and on fail-safe entry, beats writes
    if (!q.loadDone || (failSafe && !q.failSafeDly)) begin
      d.loadDone = 1'b1;
      d.expEn = nvExpCurveEnable;
      d.freq = nvDimFreqSelect;
      for (int ch = 0; ch < NCH; ch++) begin
        d.coarse[ch] = nvCoarseDuty[ch*8 +: 8];
        d.latC[ch] = nvCoarseDuty[ch*8 +: 8];
        d.fine[ch] = LPD_FINE_DEF;
        d.latF[ch] = LPD_FINE_DEF;
      end
    end
    // internal divider runs only when it is the tick source
    if (extUse || baseTick) begin
      d.divCnt = '0;
    end else begin
      d.divCnt = q.divCnt + 12'h001;
    end
    // 8-bit period counter; dither phase per period
    if (baseTick) begin
      d.baseCnt = q.baseCnt + 8'h01;
    end
    if (periodEnd) begin
      d.phase = q.phase + 4'h1;
    end
    for (int ch = 0; ch < NCH; ch++) begin
      // shared duty redirects to channel 0
      src = q.shareEn ? 8'h00 : 8'(ch);
      if (failSafe) begin
        // nv coarse only, low bits forced so no dither
        code = {nvCoarseDuty[ch*8 +: 8], LPD_FINE_DEF};
      end else if (q.expEn) begin
        code = expCode(q.latC[src]);
      end else begin
        // linear mode concatenates coarse and fine
        code = {q.latC[src], q.latF[src]};
      end
      // extra tick in (low + 1) of 16 periods; all ones always
      dith = (code[3:0] >= revPhase);
      // on ticks = upper bits plus the dither bit
      // one tick, under 1 us at the fast rates, is the shortest pulse
      if (periodEnd) begin
        d.onT[ch] = {1'b0, code[11:4]} + {8'h00, dith};
      end
      grp = (ch < NCH / 2) ? q.dimLoSync[1] : q.dimHiSync[1];
      // per channel gate; enable; external input low
      d.out[ch] = q.en[ch] && ({1'b0, q.baseCnt} < q.onT[ch])
                  && !(extPwm && grp);
    end
  end

  // state register, cleared on reset; nv load follows release
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_disabled_off;
    !q.en[0] |=> !currentOutputChannel[0];
  endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("disabled channel conducts");

  property p_full_on;
    q.en[0] && q.onT[0] == 9'h100 && !(extPwm && q.dimLoSync[1])
      |=> currentOutputChannel[0];
  endproperty
  a_full_on: assert property (p_full_on)
    else $error("full duty channel not on");

  property p_period_wrap;
    periodEnd |=> q.baseCnt == 8'h00 ##0 $changed(q.phase);
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("period counter did not wrap");

  property p_min_on;
    // dither slot 0 always adds a tick in linear mode, so never zero there
    q.loadDone && periodEnd && !q.expEn && revPhase == 4'h0
      |=> q.onT[0] != 9'h000;
  endproperty
  a_min_on: assert property (p_min_on)
    else $error("zero on time loaded");

  property p_no_dither;
    periodEnd && !failSafe && !q.expEn && !q.shareEn
      && q.latF[0] == LPD_FINE_DEF
      |=> q.onT[0] == {1'b0, $past(q.latC[0])} + 9'h001;
  endproperty
  a_no_dither: assert property (p_no_dither)
    else $error("dither active with fine all ones");

  property p_fine_held;
    regWr && regAddr == LPD_ADDR_FINE0 && q.loadDone && !failSafe
      |=> $stable(q.latF[0]);
  endproperty
  a_fine_held: assert property (p_fine_held)
    else $error("fine write changed active duty");

  property p_coarse_commit;
    regWr && regAddr == LPD_ADDR_COARSE0 && q.loadDone
      && !(failSafe && !q.failSafeDly)
      |=> q.latC[0] == $past(regWdata) && q.latF[0] == $past(q.fine[0]);
  endproperty
  a_coarse_commit: assert property (p_coarse_commit)
    else $error("coarse write not committed");

  property p_reload;
    !q.loadDone |=> q.fine[NCH-1] == LPD_FINE_DEF
      && q.freq == $past(nvDimFreqSelect) && q.loadDone;
  endproperty
  a_reload: assert property (p_reload)
    else $error("nv reload missing");

  property p_failsafe_duty;
    failSafe && periodEnd
      |=> q.onT[0] == {1'b0, $past(nvCoarseDuty[7:0])} + 9'h001;
  endproperty
  a_failsafe_duty: assert property (p_failsafe_duty)
    else $error("fail-safe duty wrong");

  property p_ext_gate;
    extPwm && q.dimHiSync[1] |=> !currentOutputChannel[NCH/2+1];
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("external pwm high but output on");

  c_dither: cover property (periodEnd && q.latF[0] != LPD_FINE_DEF);
  c_exp: cover property (q.expEn && currentOutputChannel[0]);
  c_ext_clk: cover property (extUse && baseTick);
  c_failsafe: cover property ($rose(failSafe));

endmodule
`default_nettype wire

// ### logic/lpd_pkg.sv
// constants shared by the led pwm dimming generator
package lpd_pkg;
  // register offsets
  localparam logic [5:0] LPD_ADDR_COARSE0 = 6'h00;
  localparam logic [5:0] LPD_ADDR_FINE0 = 6'h10;
  localparam logic [5:0] LPD_ADDR_CTRL = 6'h20;
  localparam logic [5:0] LPD_ADDR_FREQ = 6'h21;
  localparam logic [5:0] LPD_ADDR_EN_LO = 6'h22;
  localparam logic [5:0] LPD_ADDR_EN_HI = 6'h23;
  localparam logic [5:0] LPD_ADDR_STATUS = 6'h24;
  // control register bit positions
  localparam int LPD_CTRL_EXP = 0;
  localparam int LPD_CTRL_SHARE = 1;
  localparam int LPD_CTRL_EXTCLK = 2;
  // status register bit positions
  localparam int LPD_STAT_FAILSAFE = 0;
  localparam int LPD_STAT_EXTCLK = 1;
  // fine load value and last base count of a period
  localparam logic [3:0] LPD_FINE_DEF = 4'hF;
  localparam logic [7:0] LPD_PERIOD_LAST = 8'hFF;
  // exponential curve top segment base and lower segment offset
  localparam logic [11:0] LPD_EXP_TOP = 12'hFE0;
  localparam logic [12:0] LPD_EXP_OFS = 13'h0020;
  // core clock and dimming frequency choices in Hz, base ticks per period
  localparam int LPD_CLK_HZ = 100_000_000;
  localparam int LPD_BASE_MUL = 256;
  localparam int LPD_DIM_HZ [16] = '{200, 300, 400, 500, 600, 800, 1000,
    1200, 1600, 2000, 2500, 3200, 4000, 6400, 10000, 20800};
endpackage

// ### tb/lpd_led_load.sv
// led string load model: on-cycle count per channel
`timescale 1ns/10ps
`default_nettype none
module lpd_led_load (
  input wire logic core_clk, // sampling clock
  input wire logic clr, // clears all counts
  input wire logic [11:0] drive // current gate per string
);
  logic [16:0] onCnt [12];
  // a lit string adds one per cycle; it never shapes the timing itself
  always @(posedge core_clk) begin
    for (int k = 0; k < 12; k++) begin
      if (clr) begin
        onCnt[k] <= '0;
      end else begin
        onCnt[k] <= onCnt[k] + 17'(drive[k]);
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the pwm dimming generator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lpd_pkg::*;
  // period at frequency 15: 256 ticks of 18 cycles
  localparam int P = 4608;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] r;} lpd_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] regAddr = '0;
  logic [7:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic failSafe = 1'b0;
  logic nvIas = 1'b0;
  logic pinLo = 1'b0;
  logic pinHi = 1'b0;
  logic pinClk = 1'b0;
  logic clr = 1'b1;
  logic [11:0] outs;
  logic [7:0] rv;
  int miscompares = 0;
  int n_tests = 0;
  lpd_row_t rows [8];

  lpd_pwm_dimming i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .failSafe(failSafe), .nvExpCurveEnable(1'b0),
    .nvCoarseDuty({12{8'h03}}), .nvDimFreqSelect(4'hF),
    .nvInternalAddressSelect(nvIas), .addrOrBaseClockPin(pinClk),
    .addrOrDimInLowGroup(pinLo), .addrOrDimInHighGroup(pinHi),
    .currentOutputChannel(outs));
  lpd_led_load i_led (.core_clk(core_clk), .clr(clr), .drive(outs));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic chkv(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // read data only stands in the cycle after the strobe
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
    chkv({4'h0, rv}, {4'h0, e});
  endtask
  task automatic chkn(input int k, input logic [16:0] exp);
    n_tests++;
    if (i_led.onCnt[k] !== exp) begin
      miscompares++;
      $display("[ERR] %0t ch %0d on %0d exp %0d", $time, k,
        i_led.onCnt[k], exp);
    end
  endtask
  // exact n-cycle window, so any alignment to the period works
  task automatic measure(input int n);
    repeat (P + 40) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic close_out();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog sized a little above the whole run: four measuring windows plus their settling waits and register accesses
  initial begin
    repeat (104000) @(posedge core_clk);
    miscompares++;
    close_out();
  end

  // main sequence
  initial begin
    rows = '{'{LPD_ADDR_COARSE0, 8'h5A, 8'h5A},
      '{LPD_ADDR_FINE0, 8'h07, 8'h07}, '{LPD_ADDR_CTRL, 8'h03, 8'h03},
      '{LPD_ADDR_FREQ, 8'h0F, 8'h0F}, '{LPD_ADDR_EN_LO, 8'hA5, 8'hA5},
      '{LPD_ADDR_EN_HI, 8'h0A, 8'h0A}, '{LPD_ADDR_STATUS, 8'hFF, 8'h00},
      '{6'h3F, 8'hFF, 8'h00}};
    repeat (12) @(posedge core_clk);
    chkv(outs, 12'h000);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdchk(LPD_ADDR_FINE0, 8'h0F);
    rdchk(LPD_ADDR_FREQ, 8'h0F);
    rdchk(LPD_ADDR_COARSE0 + 6'h2, 8'h03);
    rdchk(LPD_ADDR_EN_LO, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
    end
    // fastest rate keeps dithering flicker-free and the run short
    @(posedge core_clk);
    nvIas <= 1'b1;
    pinHi <= 1'b1;
    wr(LPD_ADDR_CTRL, 8'h00);
    wr(LPD_ADDR_FINE0, 8'h0F);
    wr(LPD_ADDR_COARSE0, 8'h00);
    wr(LPD_ADDR_FINE0 + 6'h1, 8'h07);
    wr(LPD_ADDR_COARSE0 + 6'h1, 8'h0F);
    wr(LPD_ADDR_COARSE0 + 6'h2, 8'h20);
    wr(LPD_ADDR_FINE0 + 6'h2, 8'h00);
    wr(LPD_ADDR_COARSE0 + 6'h7, 8'hFF);
    wr(LPD_ADDR_EN_LO, 8'h87);
    wr(LPD_ADDR_EN_HI, 8'h00);
    measure(16 * P);
    chkn(0, 17'd288);
    chkn(1, 17'd4464);
    chkn(2, 17'd9504);
    chkn(3, 17'd0);
    chkn(7, 17'd0);
    // exp curve top code with fine zero, shared from channel 0
    wr(LPD_ADDR_FINE0, 8'h00);
    wr(LPD_ADDR_COARSE0, 8'hFF);
    wr(LPD_ADDR_CTRL, 8'h03);
    measure(P);
    chkn(0, 17'(P));
    chkn(1, 17'(P));
    chkn(2, 17'(P));
    chkn(7, 17'd0);
    // fail-safe reloads stored values and drops exp; share stays set
    @(posedge core_clk);
    failSafe <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(LPD_ADDR_COARSE0, 8'h03);
    rdchk(LPD_ADDR_CTRL, 8'h02);
    rdchk(LPD_ADDR_FINE0 + 6'h1, 8'h0F);
    rdchk(LPD_ADDR_STATUS, 8'h01);
    measure(P);
    chkn(0, 17'd72);
    chkn(1, 17'd72);
    chkn(7, 17'd0);
    @(posedge core_clk);
    failSafe <= 1'b0;
    wr(LPD_ADDR_CTRL, 8'h04);
    rdchk(LPD_ADDR_STATUS, 8'h02);
    // pin clock held still, so no base ticks arrive
    // a still pin stays far below the 1 MHz limit
    // frozen count: output stands and the new duty never loads
    wr(LPD_ADDR_COARSE0, 8'hFF);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (P) @(posedge core_clk);
    #1;
    chkv(12'(i_led.onCnt[0] % P), 12'h000);
    close_out();
  end
endmodule
`default_nettype wire
